// >>> rtl/hst_timer.sv
// Operation
// RL1: counts down like the tenth timer but in 0.01 s steps.
// RL2: software supplies a four digit BCD set value, 00.00 to 99.99.
// RL3: zero set value gives completion at once, no countdown.
// RL4: set value 00.01 is accepted but unreliable; avoid it.
// RL5: numbers 000-015 step on the free 10 ms time base.
// RL6: numbers 016-511 step only when the instruction executes.
// RL7: with long scans, software should use numbers 000-015.
// RL8: interlock off reloads present value and clears completion.
// RL9: reset leaves present value at set value, completion clear.
// RL10: non-BCD set value does not stop the timer.
// RL11: error flag on non-BCD set value, bad or out-of-range indirect word.
// RL12: zero set value completes on activation; 000-003 may lag.
// RL13: elapsed time may be short by up to one tick period.
// RL14: numbers 000-511, each defined by one instruction only.
// RL15: condition on starts timing; off reloads the set value.
// RL16: at zero with condition on, completion holds until reset.
// RL17: present value held as BCD, one step per tick, stops at zero.
// RL18: set value sampled at activation; non-BCD flags error then.
//
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

`include "hst_cfg.svh"

module hst_timer
#(
    parameter int unsigned TICK_CYCLES = `TB_CYCLES
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire hst_pkg::bus_req_t bus_req,
    output logic [`DATA_W-1:0] rd_data,
    output logic completion_flag,
    output logic error_flag,
    output var hst_pkg::bcd4_t present_value,
    output logic irq
);
    import hst_pkg::*;

    ctrl_t ctrl_q;
    bcd4_t set_value_q;
    logic [`ADDR_W-1:0] ind_addr_q;
    bcd4_t dm_q [`DM_DEPTH];
    logic [`INT_W-1:0] int_stat_q;
    logic [`INT_W-1:0] int_mask_q;
    logic [`DATA_W-1:0] rd_data_q;
    logic irq_q;

    logic [`TB_W-1:0] tb_cnt_q;
    logic tick_q;
    logic [`PEND_W-1:0] pend_q;
    logic [`PEND_W-1:0] drain_q;
    logic [`PEND_W-1:0] drain_d;
    logic [`PEND_W-1:0] pend_d;

    tstate_t state_q;
    bcd4_t pv_q;
    logic done_q;
    logic err_q;
    logic cond_prev_q;

    logic wr_hit_ctrl;
    logic wr_hit_sv;
    logic wr_hit_ind;
    logic exec_hit;
    logic wr_hit_istat;
    logic wr_hit_imask;
    logic wr_hit_dm;
    logic cond;
    logic activate;
    logic fast;
    logic lag;
    logic step;
    logic bad_addr;
    logic sv_bcd;
    logic sv_zero;
    logic fetch_err;
    logic done_evt;
    logic err_evt;
    bcd4_t sv_src;
    bcd4_t pv_dec;
    logic [`DATA_W-1:0] rd_mux;

    // bus decode
    assign wr_hit_ctrl = bus_req.wr && (bus_req.addr == `OFF_CTRL);
    assign wr_hit_sv = bus_req.wr && (bus_req.addr == `OFF_SV);
    assign wr_hit_ind = bus_req.wr && (bus_req.addr == `OFF_IND);
    assign exec_hit = bus_req.wr && (bus_req.addr == `OFF_EXEC);
    assign wr_hit_istat = bus_req.wr && (bus_req.addr == `OFF_INT_STAT);
    assign wr_hit_imask = bus_req.wr && (bus_req.addr == `OFF_INT_MASK);
    assign wr_hit_dm = bus_req.wr && (bus_req.addr[7:6] == `DM_SEL);

    // interlock gates the execution condition
    assign cond = ctrl_q.cond && ctrl_q.ilock; // RL8
    assign activate = cond && !cond_prev_q; // RL15
    assign fast = (ctrl_q.tnum <= `FAST_LAST);
    assign lag = (ctrl_q.tnum <= `LAG_LAST);

    // fast numbers ride the free time base, others only after execution
    assign step = fast ? tick_q : (drain_q != '0); // RL5 RL6

    // indirect fetch from the data memory window
    assign bad_addr = ctrl_q.ind && (ind_addr_q > `DM_LAST);
    assign sv_src = !ctrl_q.ind ? set_value_q :
                    bad_addr ? `SV_RST : dm_q[ind_addr_q[`DM_AW-1:0]];
    assign fetch_err = bad_addr || !sv_bcd; // RL11

    bcd_step u_sv_chk
    (
        .value(sv_src),
        .dec(),
        .is_bcd(sv_bcd),
        .is_zero(sv_zero)
    );

    bcd_step u_pv_dec
    (
        .value(pv_q),
        .dec(pv_dec),
        .is_bcd(),
        .is_zero()
    );

    // control registers
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_q <= `CTRL_RST;
            set_value_q <= `SV_RST;
            ind_addr_q <= '0;
            int_mask_q <= '0;
        end
        else
        begin
            if (wr_hit_ctrl)
            begin
                ctrl_q.cond <= bus_req.wdata[`CTRL_COND_BIT];
                ctrl_q.ilock <= bus_req.wdata[`CTRL_ILOCK_BIT];
                ctrl_q.ind <= bus_req.wdata[`CTRL_IND_BIT];
                ctrl_q.tnum <= bus_req.wdata[`CTRL_TNUM_LSB +: `TNUM_W];
            end
            if (wr_hit_sv)
            begin
                set_value_q <= bus_req.wdata[15:0];
            end
            if (wr_hit_ind)
            begin
                ind_addr_q <= bus_req.wdata[`ADDR_W-1:0];
            end
            if (wr_hit_imask)
            begin
                int_mask_q <= bus_req.wdata[`INT_W-1:0];
            end
        end
    end

    // data memory window, no reset needed for storage
    always_ff @(posedge core_clk)
    begin
        if (wr_hit_dm)
        begin
            dm_q[bus_req.addr[`DM_AW+1:2]] <= bus_req.wdata[15:0];
        end
    end

    // free running 10 ms time base; the first tick after activation
    // comes early, which is why elapsed time may be short
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tb_cnt_q <= '0;
            tick_q <= 1'b0;
        end
        else if (tb_cnt_q == `TB_W'(TICK_CYCLES - 1))
        begin
            tb_cnt_q <= '0;
            tick_q <= 1'b1; // RL13
        end
        else
        begin
            tb_cnt_q <= tb_cnt_q + `TB_W'(1);
            tick_q <= 1'b0;
        end
    end

    // slow numbers: ticks pile up and are spent after each execution
    always_comb
    begin
        pend_d = pend_q;
        drain_d = drain_q;
        if (drain_q != '0)
        begin
            drain_d = drain_q - `PEND_W'(1);
        end
        if (exec_hit)
        begin
            // saturates after 255 unexecuted ticks
            if ({1'b0, drain_d} + {1'b0, pend_q} > {1'b0, {`PEND_W{1'b1}}})
            begin
                drain_d = '1;
            end
            else
            begin
                drain_d = drain_d + pend_q;
            end
            pend_d = tick_q ? `PEND_W'(1) : '0;
        end
        else if (tick_q && (pend_q != '1))
        begin
            pend_d = pend_q + `PEND_W'(1);
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pend_q <= '0;
            drain_q <= '0;
        end
        else if (!cond || activate || fast)
        begin
            pend_q <= '0;
            drain_q <= '0;
        end
        else
        begin
            pend_q <= pend_d; // RL6
            drain_q <= drain_d;
        end
    end

    // timer sequence
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_q <= T_OFF;
            pv_q <= `SV_RST; // RL9
            done_q <= 1'b0; // RL9
            cond_prev_q <= 1'b0;
        end
        else
        begin
            cond_prev_q <= cond;
            if (!cond)
            begin
                state_q <= T_OFF;
                pv_q <= sv_src; // RL15 RL8
                done_q <= 1'b0; // RL8
            end
            else
            begin
                case (state_q)
                    T_OFF:
                    begin
                        pv_q <= sv_src; // RL18
                        if (sv_zero && lag)
                        begin
                            state_q <= T_ZWAIT; // RL12
                        end
                        else if (sv_zero)
                        begin
                            state_q <= T_DONE; // RL3
                            done_q <= 1'b1; // RL12
                        end
                        else
                        begin
                            // non-BCD digits still count down
                            state_q <= T_RUN; // RL10
                        end
                    end
                    T_RUN:
                    begin
                        if (step)
                        begin
                            pv_q <= pv_dec; // RL1 RL17
                            if (pv_dec == `SV_RST)
                            begin
                                state_q <= T_DONE;
                                done_q <= 1'b1; // RL16
                            end
                        end
                    end
                    T_ZWAIT:
                    begin
                        if (tick_q)
                        begin
                            state_q <= T_DONE;
                            done_q <= 1'b1; // RL12
                        end
                    end
                    T_DONE:
                    begin
                        done_q <= 1'b1; // RL16
                    end
                    default:
                    begin
                        state_q <= T_OFF;
                    end
                endcase
            end
        end
    end

    // error reflects the last activation's fetch
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            err_q <= 1'b0;
        end
        else if (activate)
        begin
            err_q <= fetch_err; // RL11 RL18
        end
    end

    // interrupt status: set wins over a same-cycle clear
    // slow numbers must not see a bare tick as their last step
    assign done_evt = cond && !done_q &&
                      (((state_q == T_ZWAIT) && tick_q) ||
                       ((state_q == T_RUN) && step && (pv_dec == `SV_RST)));
    assign err_evt = activate && fetch_err;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            int_stat_q <= '0;
        end
        else
        begin
            int_stat_q[`INT_DONE_BIT] <=
                (int_stat_q[`INT_DONE_BIT] &&
                 !(wr_hit_istat && bus_req.wdata[`INT_DONE_BIT])) ||
                done_evt || (activate && sv_zero && !lag);
            int_stat_q[`INT_ERR_BIT] <=
                (int_stat_q[`INT_ERR_BIT] &&
                 !(wr_hit_istat && bus_req.wdata[`INT_ERR_BIT])) ||
                err_evt;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(int_stat_q & int_mask_q);
        end
    end

    // read mux, unmapped addresses read zero
    always_comb
    begin
        rd_mux = '0;
        case (bus_req.addr)
            `OFF_CTRL:
            begin
                rd_mux[`CTRL_COND_BIT] = ctrl_q.cond;
                rd_mux[`CTRL_ILOCK_BIT] = ctrl_q.ilock;
                rd_mux[`CTRL_IND_BIT] = ctrl_q.ind;
                rd_mux[`CTRL_TNUM_LSB +: `TNUM_W] = ctrl_q.tnum;
            end
            `OFF_SV: rd_mux[15:0] = set_value_q;
            `OFF_IND: rd_mux[`ADDR_W-1:0] = ind_addr_q;
            `OFF_PV: rd_mux[15:0] = pv_q;
            `OFF_STAT:
            begin
                rd_mux[`STAT_DONE_BIT] = done_q;
                rd_mux[`STAT_ERR_BIT] = err_q;
                rd_mux[`STAT_RUN_BIT] = (state_q == T_RUN);
            end
            `OFF_INT_STAT: rd_mux[`INT_W-1:0] = int_stat_q;
            `OFF_INT_MASK: rd_mux[`INT_W-1:0] = int_mask_q;
            default:
            begin
                if (bus_req.addr[7:6] == `DM_SEL)
                begin
                    rd_mux[15:0] = dm_q[bus_req.addr[`DM_AW+1:2]];
                end
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_data_q <= '0;
        end
        else if (bus_req.rd)
        begin
            rd_data_q <= rd_mux;
        end
        else
        begin
            rd_data_q <= '0;
        end
    end

    assign rd_data = rd_data_q;
    assign completion_flag = done_q;
    assign error_flag = err_q;
    assign present_value = pv_q;
    assign irq = irq_q;
endmodule // hst_timer

`default_nettype wire

// >>> rtl/hst_cfg.svh
`ifndef HST_CFG_SVH
`define HST_CFG_SVH

`define ADDR_W 8
`define DATA_W 32

`define OFF_CTRL 8'h00
`define OFF_SV 8'h04
`define OFF_IND 8'h08
`define OFF_EXEC 8'h0c
`define OFF_PV 8'h10
`define OFF_STAT 8'h14
`define OFF_INT_STAT 8'h18
`define OFF_INT_MASK 8'h1c
`define DM_SEL 2'h1

`define CTRL_COND_BIT 0
`define CTRL_ILOCK_BIT 1
`define CTRL_IND_BIT 2
`define CTRL_TNUM_LSB 16
`define TNUM_W 9
`define CTRL_RST 12'h000

`define STAT_DONE_BIT 0
`define STAT_ERR_BIT 1
`define STAT_RUN_BIT 2

`define INT_W 2
`define INT_DONE_BIT 0
`define INT_ERR_BIT 1

`define DM_DEPTH 16
`define DM_AW 4
`define DM_LAST 8'h0f
`define FAST_LAST 9'h00f
`define LAG_LAST 9'h003

`define SV_RST 16'h0000
`define PEND_W 8

`define TB_PERIOD_NS 10000000
`define CLK_PERIOD_NS 10
`define TB_CYCLES (`TB_PERIOD_NS / `CLK_PERIOD_NS)
`define TB_W 20

`endif

// >>> rtl/hst_pkg.sv
`include "hst_cfg.svh"

package hst_pkg;

    typedef logic [15:0] bcd4_t;

    typedef struct packed {
        logic [`ADDR_W-1:0] addr;
        logic [`DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic [`TNUM_W-1:0] tnum;
        logic ind;
        logic ilock;
        logic cond;
    } ctrl_t;

    typedef enum logic [1:0] {
        T_OFF,
        T_RUN,
        T_ZWAIT,
        T_DONE
    } tstate_t;

endpackage

// >>> rtl/bcd_step.sv
`timescale 1ns/1ps
`default_nettype none

`include "hst_cfg.svh"

module bcd_step
(
    input wire hst_pkg::bcd4_t value,
    output var hst_pkg::bcd4_t dec,
    output logic is_bcd,
    output logic is_zero
);
    import hst_pkg::*;

    logic [4:0] borrow;
    logic [3:0] valid;
    bcd4_t raw;

    assign borrow[0] = 1'b1;

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_digit
            logic [3:0] dig;
            assign dig = value[4*g +: 4];
            assign valid[g] = (dig <= 4'h9);
            assign borrow[g+1] = borrow[g] & (dig == 4'h0);
            assign raw[4*g +: 4] = !borrow[g] ? dig :
                                   (dig == 4'h0) ? 4'h9 : dig - 4'h1;
        end
    endgenerate

    assign is_bcd = &valid;
    assign is_zero = (value == `SV_RST);
    // saturate rather than wrap to 9999
    assign dec = is_zero ? `SV_RST : raw; // RL17
endmodule // bcd_step

`default_nettype wire

// >>> tb/hst_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none

`include "hst_cfg.svh"

module hst_timer_monitor
#(
    parameter int unsigned TICK_CYCLES = 4
)
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire hst_pkg::bus_req_t bus_req,
    input wire logic [`DATA_W-1:0] rd_data,
    input wire logic completion_flag,
    input wire logic error_flag,
    input wire hst_pkg::bcd4_t present_value,
    input wire logic irq
);
    import hst_pkg::*;

    logic ctrl_wr;
    assign ctrl_wr = bus_req.wr && (bus_req.addr == `OFF_CTRL);

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    rd_idle_a:
    assert property (!$past(bus_req.rd) |-> rd_data == '0)
        else $error("read data not zero outside a read answer");
    pv_read_a:
    assert property ($past(bus_req.rd && bus_req.addr == `OFF_PV) |-> rd_data == {16'h0, $past(present_value)})
        else $error("present value read back wrong");
    stat_read_a:
    assert property ($past(bus_req.rd && bus_req.addr == `OFF_STAT)
        |-> rd_data[1:0] == {$past(error_flag), $past(completion_flag)})
        else $error("status read back wrong");
    done_hold_a:
    assert property (completion_flag && !ctrl_wr && !$past(ctrl_wr) && !$past(ctrl_wr, 2) |=> completion_flag)
        else $error("completion dropped without reset");
    done_zero_a:
    assert property ($rose(completion_flag) |-> present_value == 16'h0000)
        else $error("completion raised with present value not zero");
    // pv may only fall while software leaves the block alone
    pv_down_a:
    assert property (!$past(bus_req.wr) && !$past(bus_req.wr, 2) && !$past(bus_req.wr, 3)
        |-> present_value <= $past(present_value))
        else $error("present value rose or wrapped");
    err_move_a:
    assert property ($changed(error_flag) |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
        else $error("error flag moved without activation");
    done_fall_a:
    assert property ($fell(completion_flag) |-> $past(ctrl_wr) || $past(ctrl_wr, 2) || $past(ctrl_wr, 3))
        else $error("completion fell without condition change");
endmodule // hst_timer_monitor

bind hst_timer hst_timer_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon
(
    .core_clk(core_clk),
    .rstn(rstn),
    .bus_req(bus_req),
    .rd_data(rd_data),
    .completion_flag(completion_flag),
    .error_flag(error_flag),
    .present_value(present_value),
    .irq(irq)
);

`default_nettype wire

// >>> tb/tb_hst_timer.sv
`timescale 1ns/1ps
`default_nettype none

`include "hst_cfg.svh"

module tb_hst_timer;
    import hst_pkg::*;
    localparam int unsigned TICK = 4;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    bus_req_t req = '0;
    logic [31:0] rd_data;
    logic completion_flag;
    logic error_flag;
    bcd4_t present_value;
    logic irq;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;

    hst_timer #(.TICK_CYCLES(TICK)) uut
    (
        .core_clk(core_clk),
        .rstn(rstn),
        .bus_req(req),
        .rd_data(rd_data),
        .completion_flag(completion_flag),
        .error_flag(error_flag),
        .present_value(present_value),
        .irq(irq)
    );

    initial
    begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            end_sim();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_done(input int lim, output int n);
        n = 0;
        while (completion_flag !== 1'b1 && n < lim)
        begin
            @(posedge core_clk);
            #1;
            n++;
        end
    endtask

    task automatic start(input logic [8:0] tnum, input logic [15:0] sv);
        wr(`OFF_SV, {16'h0, sv});
        wr(`OFF_CTRL, ({23'h0, tnum} << 16) | 32'h3);
    endtask

    task automatic stop();
        wr(`OFF_CTRL, 32'h0);
        idle(3);
    endtask

    task automatic s_reset();
        chk(completion_flag, 1'b0);
        chk(present_value, 16'h0000);
        rd(`OFF_CTRL, 32'h0);
        rd(8'h24, 32'h0);
    endtask

    task automatic s_fast();
        int n;
        wr(`OFF_INT_MASK, 32'h1);
        start(9'h000, 16'h0002);
        wait_done(3 * TICK + 4, n);
        chk(completion_flag, 1'b1);
        chk(n >= TICK, 1'b1);
        idle(2 * TICK);
        chk(completion_flag, 1'b1);
        chk(present_value, 16'h0000);
        chk(irq, 1'b1);
        rd(`OFF_INT_STAT, 32'h1);
        wr(`OFF_INT_STAT, 32'h1);
        idle(3);
        chk(irq, 1'b0);
        wr(`OFF_CTRL, 32'h2);
        idle(3);
        chk(completion_flag, 1'b0);
        rd(`OFF_PV, 32'h0002);
    endtask

    task automatic s_ilock();
        start(9'h001, 16'h0009);
        idle(3 * TICK);
        chk(present_value < 16'h0009, 1'b1);
        wr(`OFF_CTRL, 32'h0001_0001);
        idle(3);
        chk(present_value, 16'h0009);
        idle(2 * TICK);
        chk(present_value, 16'h0009);
        chk(completion_flag, 1'b0);
        stop();
    endtask

    task automatic s_zero();
        int n;
        wr(`OFF_INT_MASK, 32'h0);
        start(9'h014, 16'h0000);
        wait_done(4, n);
        chk(completion_flag, 1'b1);
        // event latched but masked out
        chk(irq, 1'b0);
        rd(`OFF_INT_STAT, 32'h1);
        stop();
        start(9'h003, 16'h0000);
        wait_done(TICK + 4, n);
        chk(completion_flag, 1'b1);
        stop();
    endtask

    task automatic s_slow();
        start(9'h010, 16'h0003);
        idle(5 * TICK);
        chk(present_value, 16'h0003);
        wr(`OFF_EXEC, 32'h1);
        idle(4);
        chk(present_value, 16'h0000);
        chk(completion_flag, 1'b1);
        stop();
    endtask

    task automatic s_err();
        start(9'h000, 16'h00a5);
        idle(TICK + 3);
        chk(error_flag, 1'b1);
        chk(present_value < 16'h00a5, 1'b1);
        stop();
        wr(`OFF_IND, 32'h20);
        wr(`OFF_CTRL, 32'h7);
        idle(3);
        chk(error_flag, 1'b1);
        stop();
        rd(`OFF_STAT, 32'h2);
        wr(8'h4c, 32'h0004);
        wr(`OFF_IND, 32'h03);
        wr(`OFF_CTRL, 32'h4);
        idle(2);
        chk(present_value, 16'h0004);
        wr(`OFF_CTRL, 32'h7);
        idle(3);
        chk(error_flag, 1'b0);
        stop();
        rd(`OFF_INT_STAT, 32'h3);
    endtask

    initial
    begin
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        s_reset();
        s_fast();
        s_ilock();
        s_zero();
        s_slow();
        s_err();
        end_sim();
    end
endmodule // tb_hst_timer

`default_nettype wire
